// File: inc/axs_pkg.sv
// Constants, register map and carrier types of the auxiliary one-shot master.
// Assumes a 20 MHz aclk and an AXI4-Lite master reaching the registers.
package axs_pkg;
	// ****************************************
	// Register indices, byte address is 4 x index
	// ****************************************
	localparam logic [7:0] IDX_TARGET = 8'h31;
	localparam logic [7:0] IDX_REG_ADDR = 8'h32;
	localparam logic [7:0] IDX_WR_DATA = 8'h33;
	localparam logic [7:0] IDX_CTRL = 8'h34;
	localparam logic [7:0] IDX_RD_DATA = 8'h35;
	localparam logic [7:0] IDX_STATUS = 8'h36;
	localparam logic [7:0] IDX_PIN_CFG = 8'h37;
	localparam logic [7:0] IDX_MST_CTRL = 8'h38;
	localparam logic [7:0] IDX_DLY_SEL = 8'h39;
	localparam logic [7:0] IDX_SMPL_DIV = 8'h3a;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int DIR_BIT = 7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Pin sync order: host sda, host scl, aux sda, aux scl, framesync
	localparam logic [4:0] PIN_IDLE = 5'h1e;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SCL_PERIOD_NS = 2500;
	localparam int unsigned QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	localparam int unsigned PULSE_US = 50;
	localparam int unsigned PULSE_CYC = PULSE_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SAMPLE_US = 1000;
	localparam int unsigned SAMPLE_CYC_DEF = SAMPLE_US * 1000 / CLK_PERIOD_NS;
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic go;
		logic irq_en;
		logic skip_reg;
		logic [4:0] skip_count;
	} axs_ctrl_t;
	typedef struct packed {
		logic pol_low;
		logic open_drain;
		logic latch;
		logic anyrd_clear;
		logic fsync_low;
		logic fsync_en;
		logic bypass_en;
		logic rsvd;
	} axs_pincfg_t;
	typedef enum logic [2:0] {S_IDLE, S_START, S_BIT, S_RSTART, S_STOP} axs_state_t;
	typedef enum logic [1:0] {ST_ADDR, ST_REG, ST_ADDR2, ST_DATA} axs_step_t;

	function automatic logic [7:0] axs_baddr(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction : axs_baddr
endpackage : axs_pkg

// File: rtl/axs_oneshot_master.sv
// One-shot auxiliary I2C master channel with status flags and interrupt pin.
// Assumes an AXI4-Lite master on aclk and open-drain pins resolved outside.
`timescale 1ns/1ps
// Function
// - Address register top bit selects read, low seven bits the target.
// - Eight-bit start register address inside the target.
// - Go bit runs one transfer at sample rate using read or write byte.
// - Go bit clears itself once the transfer completes.
// - Completion interrupts only while control bit 6 is set.
// - Control bit 5 skips sending the register address.
// - Received byte readable in a read-only register.
// - Reading master status clears all its flags.
// - Status bit 7 set on enabled framesync rise, raising interrupt.
// - Status bit 6 on completion, interrupts with both enables set.
// - Status bit 5 on lost arbitration, interrupts with master enable.
// - Status bits 4..0 on channel NACKs, interrupts with master enable.
// - Config bit 7 makes interrupt pin active low.
// - Config bit 6 makes interrupt pin open drain.
// - Config bit 5 latches interrupt, else 50us pulse.
// - Config bit 4 clears status on any register read.
// - Config bit 3 makes framesync active low.
// - Config bit 2 enables framesync interrupt.
// - Config bit 1 bypasses aux pins when master disabled, else float.
module axs_oneshot_master #(
	parameter int unsigned SAMPLE_CYC = axs_pkg::SAMPLE_CYC_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic framesync_pin,
	input wire logic aux_bus_clock_pin_i,
	output logic aux_bus_clock_pin_o,
	output logic aux_bus_clock_pin_oe,
	input wire logic aux_bus_data_pin_i,
	output logic aux_bus_data_pin_o,
	output logic aux_bus_data_pin_oe,
	input wire logic host_clock_pin,
	input wire logic host_data_pin,
	input wire logic [3:0] chan_nack,
	output logic [3:0] chan_sample_en,
	output logic irq_o,
	output logic irq_oe
);
	import axs_pkg::*;

	logic [7:0] target_r, start_reg_r, wr_byte_r, rd_byte_r, status_r;
	logic [7:0] smpl_div_r;
	logic [4:0] dly_sel_r;
	axs_ctrl_t ctrl_r;
	axs_pincfg_t cfg_r;
	logic mst_en_r, mst_irq_en_r;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	logic aw_held_r, w_held_r, w_strb_r, bvalid_r, rvalid_r;
	logic [7:0] aw_addr_r, w_data_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic wr_do, rd_fire, clr_status;

	function automatic logic is_mapped(input logic [7:0] a);
		return a[1:0] == 2'b00 && a[7:2] >= IDX_TARGET[5:0] && a[7:2] <= IDX_SMPL_DIV[5:0];
	endfunction : is_mapped

	function automatic logic wr_hit(input logic [7:0] idx);
		return wr_do && w_strb_r && aw_addr_r == axs_baddr(idx);
	endfunction : wr_hit

	assign awready = !aw_held_r && !bvalid_r;
	assign wready = !w_held_r && !bvalid_r;
	assign wr_do = aw_held_r && w_held_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = !rvalid_r;
	assign rd_fire = arvalid && !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= RST_BYTE;
			w_data_r <= RST_BYTE;
			w_strb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				w_data_r <= wdata[7:0];
				w_strb_r <= wstrb[0];
			end
			if (wr_do) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= is_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case ({2'b00, a[7:2]})
			IDX_TARGET: return target_r;
			IDX_REG_ADDR: return start_reg_r;
			IDX_WR_DATA: return wr_byte_r;
			IDX_CTRL: return ctrl_r;
			IDX_RD_DATA: return rd_byte_r;
			IDX_STATUS: return status_r;
			IDX_PIN_CFG: return cfg_r;
			IDX_MST_CTRL: return {6'h00, mst_irq_en_r, mst_en_r};
			IDX_DLY_SEL: return {3'h0, dly_sel_r};
			IDX_SMPL_DIV: return smpl_div_r;
			default: return RST_BYTE;
		endcase
	endfunction : rd_mux

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= {24'h00_0000, is_mapped(araddr) ? rd_mux(araddr) : RST_BYTE};
			rresp_r <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_r && rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign clr_status = rd_fire && (araddr == axs_baddr(IDX_STATUS) || cfg_r.anyrd_clear);

	// ****************************************
	// Software registers
	// ****************************************
	logic done_ev_r, nack_ev_r, arb_ev_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			target_r <= RST_BYTE;
			start_reg_r <= RST_BYTE;
			wr_byte_r <= RST_BYTE;
			cfg_r <= RST_BYTE;
			mst_en_r <= 1'b0;
			mst_irq_en_r <= 1'b0;
			dly_sel_r <= 5'h00;
			smpl_div_r <= RST_BYTE;
		end else begin
			if (wr_hit(IDX_TARGET)) target_r <= w_data_r;
			if (wr_hit(IDX_REG_ADDR)) start_reg_r <= w_data_r;
			if (wr_hit(IDX_WR_DATA)) wr_byte_r <= w_data_r;
			if (wr_hit(IDX_PIN_CFG)) cfg_r <= {w_data_r[7:1], 1'b0};
			if (wr_hit(IDX_MST_CTRL)) begin
				mst_en_r <= w_data_r[0];
				mst_irq_en_r <= w_data_r[1];
			end
			if (wr_hit(IDX_DLY_SEL)) dly_sel_r <= w_data_r[4:0];
			if (wr_hit(IDX_SMPL_DIV)) smpl_div_r <= w_data_r;
		end
	end

	// Software write of a new go beats the self-clear of the old transfer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= RST_BYTE;
		end else if (wr_hit(IDX_CTRL)) begin
			ctrl_r <= w_data_r;
		end else if (done_ev_r || arb_ev_r) begin
			ctrl_r.go <= 1'b0;
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;
	logic fs_act_r, fs_rise;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_r <= PIN_IDLE;
			pin_s2_r <= PIN_IDLE;
			pin_s3_r <= PIN_IDLE;
			pin_lvl_r <= PIN_IDLE;
		end else begin
			pin_s1_r <= {host_data_pin, host_clock_pin, aux_bus_data_pin_i,
				aux_bus_clock_pin_i, framesync_pin};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_lvl_r <= (pin_s2_r & ~(pin_s2_r ^ pin_s3_r)) | (pin_lvl_r & (pin_s2_r ^ pin_s3_r));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) fs_act_r <= 1'b0;
		else fs_act_r <= pin_lvl_r[0] ^ cfg_r.fsync_low;
	end
	// Changing polarity may itself look like one edge
	assign fs_rise = (pin_lvl_r[0] ^ cfg_r.fsync_low) && !fs_act_r;

	// ****************************************
	// Sample rate and delay divider
	// ****************************************
	logic [31:0] base_cnt_r;
	logic [7:0] div_cnt_r;
	logic [4:0] dly_cnt_r;
	logic [7:0] qcnt_r;
	logic sample_tick, dly_hit, os_slot, qtick;

	assign sample_tick = base_cnt_r == 32'(SAMPLE_CYC - 1) && div_cnt_r == smpl_div_r;
	assign dly_hit = dly_cnt_r == ctrl_r.skip_count;
	assign os_slot = sample_tick && (!dly_sel_r[4] || dly_hit);
	assign qtick = qcnt_r == 8'(QTR_CYC - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			base_cnt_r <= 32'h0000_0000;
			div_cnt_r <= 8'h00;
			dly_cnt_r <= 5'h00;
			qcnt_r <= 8'h00;
			chan_sample_en <= 4'h0;
		end else begin
			qcnt_r <= qtick ? 8'h00 : qcnt_r + 8'h01;
			base_cnt_r <= base_cnt_r == 32'(SAMPLE_CYC - 1) ? 32'h0 : base_cnt_r + 32'h1;
			if (base_cnt_r == 32'(SAMPLE_CYC - 1)) begin
				div_cnt_r <= div_cnt_r == smpl_div_r ? 8'h00 : div_cnt_r + 8'h01;
			end
			if (sample_tick) begin
				dly_cnt_r <= dly_hit ? 5'h00 : dly_cnt_r + 5'h01;
			end
			chan_sample_en <= {4{sample_tick}} & (~dly_sel_r[3:0] | {4{dly_hit}});
		end
	end

	// ****************************************
	// One-shot bus engine
	// ****************************************
	axs_state_t state_r;
	axs_step_t step_r;
	logic [1:0] ph_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic scl_rel_r, sda_rel_r, ack_r, is_read, rx_byte, busy, start_xfer;

	assign is_read = target_r[DIR_BIT];
	assign rx_byte = is_read && step_r == ST_DATA;
	assign busy = state_r != S_IDLE;
	// start at sample rate
	// Go still reads set for one cycle after an end, so no restart then
	assign start_xfer = !busy && mst_en_r && ctrl_r.go && os_slot && !done_ev_r && !arb_ev_r;

	function automatic logic [7:0] tx_byte(input axs_step_t s);
		case (s)
			ST_ADDR: return {target_r[6:0], is_read && ctrl_r.skip_reg};
			ST_REG: return start_reg_r;
			ST_ADDR2: return {target_r[6:0], 1'b1};
			default: return wr_byte_r;
		endcase
	endfunction : tx_byte

	always_ff @(posedge aclk) begin
		done_ev_r <= 1'b0;
		nack_ev_r <= 1'b0;
		arb_ev_r <= 1'b0;
		if (!aresetn) begin
			state_r <= S_IDLE;
			step_r <= ST_ADDR;
			ph_r <= 2'd0;
			bit_r <= 4'd0;
			sh_r <= RST_BYTE;
			scl_rel_r <= 1'b1;
			sda_rel_r <= 1'b1;
			ack_r <= 1'b0;
			rd_byte_r <= RST_BYTE;
		end else if (start_xfer) begin
			state_r <= S_START;
			step_r <= ST_ADDR;
			ph_r <= 2'd0;
		end else if (busy && qtick) begin
			ph_r <= ph_r + 2'd1;
			case (state_r)
				S_START: begin
					if (ph_r == 2'd1) sda_rel_r <= 1'b0;
					if (ph_r == 2'd2) scl_rel_r <= 1'b0;
					if (ph_r == 2'd3) begin
						state_r <= S_BIT;
						bit_r <= 4'd0;
						sh_r <= tx_byte(ST_ADDR);
					end
				end
				S_BIT: begin
					if (ph_r == 2'd0) sda_rel_r <= bit_r[3] || rx_byte || sh_r[7];
					if (ph_r == 2'd1) scl_rel_r <= 1'b1;
					// Target may stretch the clock
					if (ph_r == 2'd2 && !pin_lvl_r[1]) ph_r <= ph_r;
					if (ph_r == 2'd2 && pin_lvl_r[1]) begin
						if (bit_r[3]) ack_r <= pin_lvl_r[2];
						else if (rx_byte) sh_r <= {sh_r[6:0], pin_lvl_r[2]};
						else if (sh_r[7] && !pin_lvl_r[2]) begin
							state_r <= S_IDLE;
							sda_rel_r <= 1'b1;
							arb_ev_r <= 1'b1;
						end else sh_r <= {sh_r[6:0], 1'b0};
					end
					if (ph_r == 2'd3) begin
						scl_rel_r <= 1'b0;
						bit_r <= bit_r + 4'd1;
						if (bit_r[3]) begin
							bit_r <= 4'd0;
							if (rx_byte) begin
								rd_byte_r <= sh_r;
								state_r <= S_STOP;
							end else if (ack_r) begin
								nack_ev_r <= 1'b1;
								state_r <= S_STOP;
							end else if (step_r == ST_DATA) begin
								state_r <= S_STOP;
							end else if (step_r == ST_REG && is_read) begin
								state_r <= S_RSTART;
							end else begin
								step_r <= (step_r == ST_ADDR && !ctrl_r.skip_reg) ? ST_REG : ST_DATA;
								sh_r <= tx_byte((step_r == ST_ADDR && !ctrl_r.skip_reg) ?
									ST_REG : ST_DATA);
							end
						end
					end
				end
				S_RSTART: begin
					if (ph_r == 2'd0) sda_rel_r <= 1'b1;
					if (ph_r == 2'd1) scl_rel_r <= 1'b1;
					if (ph_r == 2'd2) sda_rel_r <= 1'b0;
					if (ph_r == 2'd3) begin
						scl_rel_r <= 1'b0;
						state_r <= S_BIT;
						step_r <= ST_ADDR2;
						sh_r <= tx_byte(ST_ADDR2);
					end
				end
				S_STOP: begin
					if (ph_r == 2'd0) sda_rel_r <= 1'b0;
					if (ph_r == 2'd1) scl_rel_r <= 1'b1;
					if (ph_r == 2'd2) sda_rel_r <= 1'b1;
					if (ph_r == 2'd3) begin
						state_r <= S_IDLE;
						done_ev_r <= 1'b1;
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// bypass or float when master off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_bus_clock_pin_oe <= 1'b0;
			aux_bus_data_pin_oe <= 1'b0;
		end else if (mst_en_r) begin
			aux_bus_clock_pin_oe <= !scl_rel_r;
			aux_bus_data_pin_oe <= !sda_rel_r;
		end else begin
			aux_bus_clock_pin_oe <= cfg_r.bypass_en && !pin_lvl_r[3];
			aux_bus_data_pin_oe <= cfg_r.bypass_en && !pin_lvl_r[4];
		end
	end
	assign aux_bus_clock_pin_o = 1'b0;
	assign aux_bus_data_pin_o = 1'b0;

	// ****************************************
	// Status flags and interrupt pin
	// ****************************************
	logic [7:0] set_vec, gset;
	logic [15:0] pulse_cnt_r;
	logic pend, irq_act;

	assign set_vec = {fs_rise && cfg_r.fsync_en, done_ev_r, arb_ev_r, nack_ev_r, chan_nack};
	assign gset = set_vec & {1'b1, ctrl_r.irq_en && mst_irq_en_r, {6{mst_irq_en_r}}};
	assign pend = |(status_r & {1'b1, ctrl_r.irq_en && mst_irq_en_r, {6{mst_irq_en_r}}});

	// Set beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) status_r <= RST_BYTE;
		else status_r <= (clr_status ? RST_BYTE : status_r) | set_vec;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) pulse_cnt_r <= 16'h0000;
		else if (|gset) pulse_cnt_r <= 16'(PULSE_CYC);
		else if (pulse_cnt_r != 16'h0000) pulse_cnt_r <= pulse_cnt_r - 16'h0001;
	end
	assign irq_act = cfg_r.latch ? pend : pulse_cnt_r != 16'h0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_o <= 1'b0;
			irq_oe <= 1'b1;
		end else begin
			irq_o <= !cfg_r.open_drain && (irq_act ^ cfg_r.pol_low);
			irq_oe <= !cfg_r.open_drain || !(irq_act ^ cfg_r.pol_low);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	go_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_ev_r && !wr_hit(IDX_CTRL) |=> !ctrl_r.go) else $error("go not cleared");
	done_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
		done_ev_r |=> status_r[6]) else $error("done flag missing");
	status_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clr_status && set_vec == 8'h00 |=> status_r == 8'h00) else $error("status kept");
	push_pull_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg_r.open_drain && $stable(cfg_r) |=> irq_oe && irq_o == $past(irq_act ^ cfg_r.pol_low))
		else $error("irq level wrong");
	open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_r.open_drain && $stable(cfg_r) |=> !irq_o && irq_oe == !$past(irq_act ^ cfg_r.pol_low))
		else $error("open drain wrong");
	pulse_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
		pulse_cnt_r == 16'h0001 && gset == 8'h00 |=> pulse_cnt_r == 16'h0000)
		else $error("pulse too long");
	pulse_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		|gset |=> pulse_cnt_r == 16'(PULSE_CYC)) else $error("pulse not loaded");
	bus_float_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!mst_en_r && !cfg_r.bypass_en ##1 !mst_en_r |-> !aux_bus_clock_pin_oe && !aux_bus_data_pin_oe)
		else $error("pins not floating");
	fsync_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(status_r[7]) |-> $past(cfg_r.fsync_en)) else $error("fsync flag ungated");
	skip_reg_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_r.skip_reg && state_r == S_BIT && $stable(ctrl_r) |-> step_r != ST_REG)
		else $error("register sent");
	start_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(busy) |-> $past(os_slot && ctrl_r.go && mst_en_r)) else $error("start off slot");
endmodule : axs_oneshot_master

// File: verification/axs_target_model.sv
// Aux bus target: one register pointer, one data byte, acks its own address.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/1ps
module axs_target_model #(
	parameter logic [6:0] ADDR = 7'h50
) (
	input wire logic scl,
	input wire logic sda,
	output logic sda_oe,
	output logic [7:0] ptr,
	output logic [7:0] mem,
	output int starts
);
	logic [7:0] sh;
	logic sel, rnw;
	int bitn, byten;
	initial begin
		sda_oe = 1'b0;
		starts = 0;
		mem = 8'h3c;
		ptr = 8'h00;
		sh = 8'h00;
		sel = 1'b0;
		rnw = 1'b0;
		bitn = 0;
		byten = 0;
	end
	// ****************************************
	// Framing, seen only while clock is high
	// ****************************************
	always @(negedge sda) if (scl) begin
		starts++;
		bitn = 0;
		byten = 0;
	end
	always @(posedge sda) if (scl) sel = 1'b0;
	// Bits counted on the rising clock, so the low clock after a start adds none
	always @(posedge scl) begin
		bitn++;
		if (bitn <= 8) sh = {sh[6:0], sda};
		// Master nack ends our read drive
		if (bitn == 9 && rnw && byten > 0 && sda) sel = 1'b0;
	end
	// Drive changes only with clock low, so no false start or stop
	always @(negedge scl) begin
		if (bitn == 8 && byten == 0) begin
			sel = (sh[7:1] == ADDR);
			rnw = sh[0];
		end
		if (bitn == 8 && sel && !rnw && byten == 1) ptr = sh;
		if (bitn == 8 && sel && !rnw && byten > 1) mem = sh;
		if (bitn == 9) begin
			bitn = 0;
			byten++;
		end
		if (sel && rnw && byten > 0) sda_oe = (bitn < 8) && !mem[7 - bitn];
		else sda_oe = sel && (bitn == 8);
	end
endmodule : axs_target_model

// File: verification/aux_i2c_single_xfer_status_intpin_bench.sv
// Bench of the one-shot aux master: registers, transfers, status and pins.
// Assumes a pulled-up aux bus with one target model at address 7'h50.
`timescale 1ns/1ps
module aux_i2c_single_xfer_status_intpin_bench;
	import axs_pkg::*;
	// Short sample period keeps each transfer under two thousand cycles
	localparam int unsigned SC = 40;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic awready, wready, arready, fs, hcl, hda, scl_oe, sda_oe, irq_o, irq_oe, t_oe;
	logic [7:0] awaddr, araddr, v, t_ptr, t_mem;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] chan_nack, cse;
	logic scl_o, sda_o;
	int failures = 0, tests_run = 0, irq_hi = 0, t_starts, sen0 = 0, sen1 = 0;
	wire scl = !scl_oe;
	wire sda = !(sda_oe || t_oe);
	axs_oneshot_master #(.SAMPLE_CYC(SC)) i_axs_oneshot_master (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .framesync_pin(fs),
		.aux_bus_clock_pin_i(scl), .aux_bus_clock_pin_o(scl_o), .aux_bus_clock_pin_oe(scl_oe),
		.aux_bus_data_pin_i(sda), .aux_bus_data_pin_o(sda_o), .aux_bus_data_pin_oe(sda_oe),
		.host_clock_pin(hcl), .host_data_pin(hda), .chan_nack(chan_nack),
		.chan_sample_en(cse), .irq_o(irq_o), .irq_oe(irq_oe));
	axs_target_model i_axs_target_model (.scl(scl), .sda(sda), .sda_oe(t_oe), .ptr(t_ptr),
		.mem(t_mem), .starts(t_starts));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	// Cycles of asserted push-pull active-high interrupt
	always @(posedge aclk) irq_hi <= irq_hi + (irq_o && irq_oe);
	// Sample slot pulses of channels 0 and 1
	always @(posedge aclk) begin
		sen0 <= sen0 + cse[0];
		sen1 <= sen1 + cse[1];
	end
	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task automatic complete_run();
		if (failures == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		chk(n < 99, 1'b1);
		if (n == 99) complete_run();
		// One edge with bready low before the next request
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 99; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata[7:0];
		resp = rresp;
		rready <= 1'b0;
		chk(n < 99, 1'b1);
		if (n == 99) complete_run();
		@(posedge aclk);
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rchk
	task automatic wait_go();
		int n;
		for (n = 0; n < 2000; n++) begin
			rd(8'hd0, v);
			if (v[7] === 1'b0) break;
		end
		chk(v[7], 1'b0);
		if (n == 2000) complete_run();
	endtask : wait_go
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_reset();
		logic [7:0] ad [5] = '{8'hc4, 8'hc8, 8'hcc, 8'hd0, 8'hdc};
		foreach (ad[i]) rchk(ad[i], RST_BYTE);
		rd(8'hfc, v);
		chk(resp, RESP_SLVERR);
	endtask : s_reset
	task automatic s_write();
		int s;
		wr(8'he0, 8'h03);
		wr(8'hc4, 8'h50);
		wr(8'hc8, 8'h12);
		wr(8'hcc, 8'ha5);
		s = irq_hi;
		wr(8'hd0, 8'hc0);
		wait_go();
		chk(t_ptr, 8'h12);
		chk(t_mem, 8'ha5);
		repeat (PULSE_CYC + 50) @(posedge aclk);
		chk(irq_hi - s, PULSE_CYC);
		rchk(8'hd8, 8'h40);
		rchk(8'hd8, 8'h00);
	endtask : s_write
	task automatic s_read();
		int s, n;
		s = irq_hi;
		n = t_starts;
		wr(8'hc4, 8'hd0);
		wr(8'hd0, 8'h80);
		wait_go();
		chk(t_starts - n, 2);
		rchk(8'hd4, 8'ha5);
		n = t_starts;
		wr(8'hd0, 8'ha0);
		wait_go();
		chk(t_starts - n, 1);
		wr(8'hd4, 8'h77);
		rchk(8'hd4, 8'ha5);
		chk(irq_hi - s, 0);
		rchk(8'hd8, 8'h40);
	endtask : s_read
	task automatic s_nack();
		wr(8'hc4, 8'h33);
		wr(8'hd0, 8'h80);
		wait_go();
		rchk(8'hd8, 8'h50);
		chan_nack <= 4'h4;
		@(posedge aclk);
		chan_nack <= 4'h0;
		rchk(8'hd8, 8'h04);
	endtask : s_nack
	task automatic s_pin();
		wr(8'hdc, 8'he4);
		fs <= 1'b1;
		repeat (PULSE_CYC + 50) @(posedge aclk);
		chk({irq_oe, irq_o}, 2'b10);
		rchk(8'hd8, 8'h80);
		repeat (4) @(posedge aclk);
		chk({irq_oe, irq_o}, 2'b00);
		wr(8'hdc, 8'h1c);
		fs <= 1'b0;
		repeat (10) @(posedge aclk);
		rchk(8'hd8, 8'h80);
		fs <= 1'b1;
		repeat (10) @(posedge aclk);
		fs <= 1'b0;
		repeat (10) @(posedge aclk);
		rd(8'hc8, v);
		rchk(8'hd8, 8'h00);
		wr(8'hdc, 8'h00);
		fs <= 1'b1;
		repeat (10) @(posedge aclk);
		rchk(8'hd8, 8'h00);
	endtask : s_pin
	task automatic s_delay();
		int a, b;
		// Channel 0 delayed, skip count 2, go left clear
		wr(8'he4, 8'h01);
		wr(8'hd0, 8'h02);
		repeat (3 * SC) @(posedge aclk);
		a = sen0;
		b = sen1;
		repeat (12 * SC) @(posedge aclk);
		chk(sen1 - b, 12);
		chk(sen0 - a, 4);
		wr(8'he4, 8'h00);
	endtask : s_delay
	task automatic s_bypass();
		wr(8'he0, 8'h00);
		wr(8'hdc, 8'h02);
		// Host clock at 400 ns, unrelated to the master's own bus timing
		repeat (6) begin
			hcl <= ~hcl;
			repeat (4) @(posedge aclk);
		end
		hcl <= 1'b0;
		hda <= 1'b0;
		repeat (8) @(posedge aclk);
		chk({scl_oe, sda_oe}, 2'b11);
		chk({scl_o, sda_o}, 2'b00);
		wr(8'hdc, 8'h00);
		repeat (8) @(posedge aclk);
		chk({scl_oe, sda_oe}, 2'b00);
	endtask : s_bypass
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, fs, chan_nack} = '0;
		{awaddr, araddr, wdata} = '0;
		{hcl, hda} = 2'b11;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset();
		s_write();
		s_read();
		s_nack();
		s_pin();
		s_delay();
		s_bypass();
		complete_run();
	end
endmodule : aux_i2c_single_xfer_status_intpin_bench
